// [core/mrc_params.svh]
// Offsets, field positions, reset values and counts of the mode/RAM register block
`ifndef MRC_PARAMS_SVH
`define MRC_PARAMS_SVH
`define MRC_MODE_OFS    12'h000
`define MRC_RAMC_OFS    12'h004
`define MRC_EXPANDED_MODE_ENABLE_BIT    7
`define MRC_ONCHIP_RAM_ENABLE_BIT    0
`define MRC_MODE_FIXED  8'h64
`define MRC_ONCHIP_RAM_ENABLE_RST    1'b1
`define MRC_STRAP_WAIT  2'h3
`define MRC_RESP_OKAY   2'h0
`define MRC_RESP_SLVERR 2'h2
`endif

// [core/mrc_pkg.sv]
// Types shared by the mode/RAM register block
package mrc_pkg;
  typedef logic [1:0]  mrc_resp_t;
  typedef logic [1:0]  mrc_mode_t;
  typedef logic [31:0] mrc_word_t;
  typedef logic [3:0]  mrc_strb_t;
endpackage

// [core/mrc_regs.sv]
// Operating mode register and on-chip RAM enable behind an AXI4-Lite slave
//
// Summary of operation
// [RULE1] An 8-bit operating mode register reports the current chip mode.
// [RULE2] Bits 1:0 are read-only, mirroring high and low mode pins.
// [RULE3] Each read of the mode register latches the present mode pin levels.
// [RULE4] Bit 7 and the mode select bits start from the mode pins.
// [RULE5] Bits 6 and 5 ignore writes and read as 1.
// [RULE6] Bits 4 and 3 ignore writes and read as 0.
// [RULE7] Bit 2 ignores writes and reads as 1.
// [RULE8] Without the flash option bit 7 ignores writes and reads as 1.
// [RULE9] RAM enable at 0 disables on-chip RAM, at 1 enables it.
// [RULE10] Reset sets RAM enable; software standby leaves it unchanged.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mrc_params.svh"

module mrc_regs #(
  parameter int ADDR_W     = 12,
  parameter bit HAS_FLASH  = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              mode_pin_hi,
  input  wire logic              mode_pin_lo,
  input  wire logic              soft_standby,
  output      logic              onchip_ram_enable,
  output      mrc_pkg::mrc_mode_t mode_select,
  output      logic              expanded_mode_enable,
  output      logic              mode_valid,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire mrc_pkg::mrc_word_t s_axi_wdata,
  input  wire mrc_pkg::mrc_strb_t s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      mrc_pkg::mrc_resp_t s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      mrc_pkg::mrc_word_t s_axi_rdata,
  output      mrc_pkg::mrc_resp_t s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import mrc_pkg::*;

  if (ADDR_W < 3 || ADDR_W > 12) begin : g_bad_addr_w
    $error("mrc_regs: ADDR_W must lie in 3..12");
  end

  // Pin synchroniser: three stages, accepted once stages two and three agree
  mrc_mode_t   pin_s1;
  mrc_mode_t   pin_s2;
  mrc_mode_t   pin_s3;
  mrc_mode_t   pins;
  logic [1:0]  strap_cnt;
  logic        strap_done;

  // No reset: the stages keep sampling during reset, so the straps are settled at release
  always_ff @(posedge core_clk) begin
    pin_s1 <= {mode_pin_hi, mode_pin_lo};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= 2'h0;
    end else if (pin_s2 == pin_s3) begin
      pins <= pin_s3;
    end
  end

  // Straps are caught only after the pipeline has filled past reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != `MRC_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  logic strap_now;
  assign strap_now = (strap_cnt == `MRC_STRAP_WAIT) && !strap_done;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_done <= 1'b0;
    end else if (strap_now) begin
      strap_done <= 1'b1;
    end
  end

  // Read channel
  logic        ar_take;
  logic        ar_mode;
  logic        ar_ramc;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_mode = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`MRC_MODE_OFS);
  assign ar_ramc = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`MRC_RAMC_OFS);

  // Write channel: address and data may arrive in either order
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  mrc_word_t         w_data;
  mrc_strb_t         w_strb;
  logic              w_held;
  logic              wr_go;
  logic              wr_mode;
  logic              wr_ramc;
  logic              lane0;

  assign wr_go   = aw_held && w_held && !s_axi_bvalid;
  assign wr_mode = {aw_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(`MRC_MODE_OFS);
  assign wr_ramc = {aw_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(`MRC_RAMC_OFS);
  assign lane0   = w_strb[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held       <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && strap_done;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held       <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && strap_done;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MRC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_mode || wr_ramc) ? `MRC_RESP_OKAY : `MRC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mode select bits: straps first, then relatched on every mode register read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_select <= 2'h0;
    end else if (strap_now || (ar_take && ar_mode)) begin
      mode_select <= pins; // [RULE2] [RULE3] [RULE4]
    end
  end

  // Bit 7 is writable only on the flash variant; otherwise it stays 1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      expanded_mode_enable <= 1'b1;
    end else if (!HAS_FLASH) begin
      expanded_mode_enable <= 1'b1; // [RULE8]
    end else if (strap_now) begin
      expanded_mode_enable <= pins[1]; // [RULE4]
    end else if (wr_go && wr_mode && lane0) begin
      expanded_mode_enable <= w_data[`MRC_EXPANDED_MODE_ENABLE_BIT];
    end
  end

  // Standby is only an input here so the enable is visibly not cleared by it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      onchip_ram_enable <= `MRC_ONCHIP_RAM_ENABLE_RST; // [RULE10]
    end else if (wr_go && wr_ramc && lane0) begin
      onchip_ram_enable <= w_data[`MRC_ONCHIP_RAM_ENABLE_BIT]; // [RULE9]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_valid <= 1'b0;
    end else begin
      mode_valid <= strap_done;
    end
  end

  // Read data built from live pins so the answer matches the fresh latch
  logic [7:0] mode_rd;
  always_comb begin
    mode_rd      = `MRC_MODE_FIXED; // [RULE5] [RULE6] [RULE7]
    mode_rd[7]   = HAS_FLASH ? expanded_mode_enable : 1'b1; // [RULE8]
    mode_rd[1:0] = pins; // [RULE3]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `MRC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (ar_mode || ar_ramc) ? `MRC_RESP_OKAY : `MRC_RESP_SLVERR;
      if (ar_mode) begin
        s_axi_rdata <= {24'h0, mode_rd}; // [RULE1]
      end else if (ar_ramc) begin
        s_axi_rdata <= {31'h0, onchip_ram_enable};
      end else begin
        s_axi_rdata <= '0;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= strap_done && !s_axi_rvalid;
    end
  end

  // Checks
  logic mode_rd_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_rd_q <= 1'b0;
    end else if (ar_take) begin
      mode_rd_q <= ar_mode;
    end
  end

  sequence seq_mode_read;
    ar_take && ar_mode;
  endsequence

  sequence seq_ram_write(v);
    wr_go && wr_ramc && lane0 && w_data[0] == v;
  endsequence

  AST_MODE_WIDTH: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    s_axi_rvalid && mode_rd_q |-> s_axi_rdata[31:8] == 24'h0)
    else $error("mode register upper bits not zero");

  AST_SEL_LATCH: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    seq_mode_read |=> s_axi_rdata[1:0] == $past(pins) && mode_select == $past(pins))
    else $error("mode select not latched at read");

  AST_SEL_RO: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
    strap_done && !(ar_take && ar_mode) |=> $stable(mode_select))
    else $error("mode select changed without a read");

  AST_STRAP: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    strap_now |=> mode_select == $past(pins) && strap_done)
    else $error("strap not captured");

  AST_RSV_65: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    s_axi_rvalid && mode_rd_q |-> s_axi_rdata[6:5] == 2'h3)
    else $error("bits 6:5 not one");

  AST_RSV_43: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    s_axi_rvalid && mode_rd_q |-> s_axi_rdata[4:3] == 2'h0)
    else $error("bits 4:3 not zero");

  AST_RSV_2: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
    s_axi_rvalid && mode_rd_q |-> s_axi_rdata[2])
    else $error("bit 2 not one");

  AST_BIT7: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
    !HAS_FLASH && s_axi_rvalid && mode_rd_q |-> s_axi_rdata[7] && expanded_mode_enable)
    else $error("bit 7 not one without flash option");

  AST_RAM_SET: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    seq_ram_write(1'b1) |=> onchip_ram_enable && s_axi_bvalid)
    else $error("RAM enable not set by write");

  AST_RAM_CLR: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    seq_ram_write(1'b0) |=> !onchip_ram_enable && s_axi_bvalid)
    else $error("RAM enable not cleared by write");

  AST_RAM_RST: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
    $past(rst) |-> onchip_ram_enable)
    else $error("RAM enable not one after reset");

  AST_RAM_STBY: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
    soft_standby && !wr_go |=> $stable(onchip_ram_enable))
    else $error("RAM enable changed in standby");

endmodule

// [tb/mrc_regs_tb.sv]
// Self-checking bench for the mode/RAM register block
`timescale 1ns/1ps
`include "mrc_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module mrc_regs_tb;
  import mrc_pkg::*;
  logic        core_clk, rst, mode_pin_hi, mode_pin_lo, soft_standby;
  logic        onchip_ram_enable, expanded_mode_enable, mode_valid;
  mrc_mode_t   mode_select;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  mrc_word_t   s_axi_wdata, s_axi_rdata, rd;
  mrc_strb_t   s_axi_wstrb;
  mrc_resp_t   s_axi_bresp, s_axi_rresp, rs;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic        f_expanded_mode_enable;
  mrc_word_t   f_rdata;

  mrc_regs dut_u (.core_clk, .rst, .mode_pin_hi, .mode_pin_lo, .soft_standby,
    .onchip_ram_enable, .mode_select, .expanded_mode_enable, .mode_valid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // Flash variant shares every input; only its bit 7 behaves differently
  mrc_regs #(.HAS_FLASH(1'b1)) dut_flash_u (.core_clk, .rst, .mode_pin_hi, .mode_pin_lo,
    .soft_standby, .onchip_ram_enable(), .mode_select(), .expanded_mode_enable(f_expanded_mode_enable),
    .mode_valid(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(f_rdata),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // A hung handshake ends here rather than spinning forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // Address and data go out together; each is dropped at its own take
  task automatic wr(input logic [11:0] a, input mrc_word_t d, input mrc_strb_t s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge so a following call never re-raises bready in the same step
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [11:0] a, input mrc_word_t e, input mrc_resp_t er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    `CHK("rdata", e, rd)
    `CHK("rresp", er, rs)
  endtask

  task automatic wait_ready;
    while (mode_valid !== 1'b1) @(posedge core_clk);
    @(posedge core_clk);
  endtask

  initial begin
    rst = 1'b1;
    mode_pin_hi = 1'b1;
    mode_pin_lo = 1'b0;
    soft_standby = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    wait_ready();
    `CHK("ram_en", 1'b1, onchip_ram_enable)
    `CHK("mode_sel", 2'b10, mode_select)
    `CHK("expanded_mode_enable", 1'b1, expanded_mode_enable)
    `CHK("f_expanded_mode_enable", 1'b1, f_expanded_mode_enable)
    rdc(`MRC_MODE_OFS, 32'h0000_00e6, `MRC_RESP_OKAY);
    `CHK("f_mode", 32'h0000_00e6, f_rdata)
    // Both writes leave every bit alone, except bit 7 of the flash variant
    wr(`MRC_MODE_OFS, 32'h0000_0000, 4'hf);
    `CHK("bresp", `MRC_RESP_OKAY, rs)
    rdc(`MRC_MODE_OFS, 32'h0000_00e6, `MRC_RESP_OKAY);
    `CHK("f_mode_wr0", 32'h0000_0066, f_rdata)
    wr(`MRC_MODE_OFS, 32'h0000_00ff, 4'hf);
    rdc(`MRC_MODE_OFS, 32'h0000_00e6, `MRC_RESP_OKAY);
    `CHK("f_mode_wr1", 32'h0000_00e6, f_rdata)
    mode_pin_hi <= 1'b0;
    mode_pin_lo <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("sel_hold", 2'b10, mode_select)
    rdc(`MRC_MODE_OFS, 32'h0000_00e5, `MRC_RESP_OKAY);
    `CHK("sel_latch", 2'b01, mode_select)
    rdc(`MRC_RAMC_OFS, 32'h0000_0001, `MRC_RESP_OKAY);
    wr(`MRC_RAMC_OFS, 32'h0000_0000, 4'hf);
    `CHK("ram_off", 1'b0, onchip_ram_enable)
    rdc(`MRC_RAMC_OFS, 32'h0000_0000, `MRC_RESP_OKAY);
    soft_standby <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK("ram_stby", 1'b0, onchip_ram_enable)
    soft_standby <= 1'b0;
    // A write with no byte lane enabled must not move the bit
    wr(`MRC_RAMC_OFS, 32'h0000_0001, 4'h0);
    `CHK("ram_nostrb", 1'b0, onchip_ram_enable)
    wr(`MRC_RAMC_OFS, 32'h0000_0001, 4'h1);
    `CHK("ram_on", 1'b1, onchip_ram_enable)
    wr(`MRC_RAMC_OFS, 32'h0000_0000, 4'h1);
    `CHK("ram_off2", 1'b0, onchip_ram_enable)
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    `CHK("ram_in_rst", 1'b1, onchip_ram_enable)
    rst <= 1'b0;
    wait_ready();
    `CHK("ram_rst", 1'b1, onchip_ram_enable)
    `CHK("sel_rst", 2'b01, mode_select)
    `CHK("f_expanded_mode_enable_rst", 1'b0, f_expanded_mode_enable)
    rdc(`MRC_MODE_OFS, 32'h0000_00e5, `MRC_RESP_OKAY);
    `CHK("f_mode_rst", 32'h0000_0065, f_rdata)
    rdc(12'h008, 32'h0000_0000, `MRC_RESP_SLVERR);
    wr(12'h008, 32'h0000_0000, 4'hf);
    `CHK("bresp_bad", `MRC_RESP_SLVERR, rs)
    `CHK("ram_keep", 1'b1, onchip_ram_enable)
    finish_test();
  end
endmodule
